// ### include/dft_pkg.sv
// How it works
// - stable flag needs two in-tolerance samples, live clock
// - off exit with select X1 waits stable
// - self-clocked monitoring starts after stable flag
// - entering off clears the stable flag
// - filter drives oscillator; upper nibble readable
// - filter writable only when select is 00
// - upper write loads full 12-bit filter
// - upper write ignored while latch pending
// - trim spans about +/-25% of nominal period
// - trim bits are binary weighted
// - larger trim value gives longer period
// - mode status encodes 00/01/10/11 modes
package dft_pkg;
	localparam logic [2:0] ADDR_STATUS_TWO   = 3'h0;
	localparam logic [2:0] ADDR_FILTER_UPPER = 3'h1;
	localparam logic [2:0] ADDR_FILTER_LOWER = 3'h2;
	localparam logic [2:0] ADDR_TRIM         = 3'h3;
	localparam logic [2:0] ADDR_CONTROL      = 3'h4;
	localparam logic [2:0] ADDR_MODE_STATUS  = 3'h5;
	localparam int         STABLE_BIT        = 0;
	localparam int         CTRL_SEL_LSB      = 0;
	localparam int         CTRL_OFF_BIT      = 2;
	localparam int         MODE_LSB          = 6;
	localparam logic [1:0] SEL_SELF          = 2'h0;
	localparam logic [1:0] SEL_INT_LOOP      = 2'h1;
	localparam logic [1:0] SEL_EXT_BYPASS    = 2'h2;
	localparam logic [1:0] SEL_EXT_LOOP      = 2'h3;
	localparam logic [11:0] FILTER_RESET     = 12'h000;
	localparam logic [7:0] TRIM_RESET        = 8'h80;
	localparam logic [7:0] CONTROL_RESET     = 8'h04;
	localparam logic [7:0] UNLOCK_TOL        = 8'h04;
	localparam int         LATCH_CYCLES      = 3;
	localparam int         SAMPLE_PERIOD_NS  = 1000;
	localparam int         CLK_PERIOD_NS     = 25;
	localparam int         SAMPLE_CYCLES     = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int         STATIC_LIMIT      = 2;
	typedef enum logic [1:0] {ST_OFF, ST_WAIT, ST_RUN} dft_state_t;
endpackage

// ### design/dft_sample_check.sv
module dft_sample_check
	import dft_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       resetn_i,
	// control
	input  wire logic       clear_i,
	input  wire logic       sample_i,
	input  wire logic [7:0] count_i,
	input  wire logic       osc_edge_i,
	// result
	output logic            stable_o
);
	logic [7:0] prev_r;
	logic [1:0] good_r;
	logic [1:0] live_r;
	logic [7:0] diff;

	always_comb
	begin
		diff = (count_i > prev_r) ? count_i - prev_r : prev_r - count_i;
	end

	// oscillator seen toggling within recent sample windows
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			live_r <= 2'h0;
		else if (clear_i)
			live_r <= 2'h0;
		else if (osc_edge_i)
			live_r <= 2'(STATIC_LIMIT);
		else if (sample_i && live_r != 2'h0)
			live_r <= live_r - 2'h1;
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			prev_r <= 8'h00;
			good_r <= 2'h0;
		end
		else if (clear_i)
		begin
			prev_r <= 8'h00;
			good_r <= 2'h0;
		end
		else if (sample_i)
		begin
			prev_r <= count_i;
			if (diff <= UNLOCK_TOL && live_r != 2'h0)
				good_r <= (good_r == 2'h2) ? 2'h2 : good_r + 2'h1;
			else
				good_r <= 2'h0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			stable_o <= 1'b0;
		else
			stable_o <= !clear_i && good_r == 2'h2 && live_r != 2'h0;
	end
endmodule

// ### design/dft_filter_trim.sv
module dft_filter_trim
	import dft_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        resetn_i,
	// register port
	input  wire logic [2:0]  addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [7:0]  rdata_o,
	// oscillator side
	input  wire logic        osc_output_clock_i,
	input  wire logic [7:0]  osc_count_i,
	// generator outputs
	output logic      [11:0] loop_filter_value_o,
	output logic      [7:0]  ref_trim_o,
	output logic      [1:0]  clock_mode_status_field_o,
	output logic             osc_monitor_en_o,
	output logic             osc_off_o
);
	dft_state_t  state_r;
	logic [11:0] filter_r;
	logic [7:0]  lower_stage_r;
	logic [7:0]  trim_r;
	logic [1:0]  sel_r;
	logic        off_r;
	logic [1:0]  mode_r;
	logic [1:0]  latch_cnt_r;
	logic [5:0]  samp_cnt_r;
	logic        sample_tick;
	logic        osc_prev_r;
	logic        stable;
	logic        clear_stable;
	logic        self_sel;
	logic        upper_wr;
	logic        lower_wr;
	logic [7:0]  rd_value;

	assign self_sel     = (sel_r == SEL_SELF);
	assign lower_wr     = wr_i && self_sel && addr_i == ADDR_FILTER_LOWER;
	assign upper_wr     = wr_i && self_sel && addr_i == ADDR_FILTER_UPPER
		&& latch_cnt_r == 2'h0;
	assign clear_stable = (state_r == ST_OFF);
	assign sample_tick  = (samp_cnt_r == 6'(SAMPLE_CYCLES - 1));

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			samp_cnt_r <= 6'h00;
		end
		else if (sample_tick)
		begin
			samp_cnt_r <= 6'h00;
		end
		else
		begin
			samp_cnt_r <= samp_cnt_r + 6'h01;
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			osc_prev_r <= 1'b0;
		end
		else
		begin
			osc_prev_r <= osc_output_clock_i;
		end
	end

	dft_sample_check u_check
	(
		.sys_clk_i  (sys_clk_i),
		.resetn_i   (resetn_i),
		.clear_i    (clear_stable),
		.sample_i   (sample_tick),
		.count_i    (osc_count_i),
		.osc_edge_i (osc_prev_r != osc_output_clock_i),
		.stable_o   (stable)
	);

	// control register: clock select and off request
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			sel_r <= CONTROL_RESET[CTRL_SEL_LSB +: 2];
			off_r <= CONTROL_RESET[CTRL_OFF_BIT];
		end
		else if (wr_i && addr_i == ADDR_CONTROL)
		begin
			sel_r <= wdata_i[CTRL_SEL_LSB +: 2];
			off_r <= wdata_i[CTRL_OFF_BIT];
		end
	end

	// mode sequencer
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state_r <= ST_OFF;
		end
		else
		begin
			case (state_r)
				ST_OFF:
				begin
					if (!off_r)
					begin
						state_r <= sel_r[0] ? ST_WAIT : ST_RUN;
					end
				end
				ST_WAIT:
				begin
					if (off_r)
					begin
						state_r <= ST_OFF;
					end
					else if (stable)
					begin
						state_r <= ST_RUN;
					end
				end
				ST_RUN:
				begin
					if (off_r)
					begin
						state_r <= ST_OFF;
					end
				end
				default:
				begin
					state_r <= ST_OFF;
				end
			endcase
		end
	end

	// reported mode follows select once the requested source is usable
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			mode_r <= SEL_SELF;
		end
		else if (state_r == ST_WAIT && !off_r && stable)
		begin
			mode_r <= sel_r;
		end
		else if (state_r == ST_RUN && !off_r && (!sel_r[0] || stable))
		begin
			mode_r <= sel_r;
		end
	end

	// latch sequence: upper writes refused while this counts down
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			latch_cnt_r <= 2'h0;
		end
		else if (upper_wr)
		begin
			latch_cnt_r <= 2'(LATCH_CYCLES);
		end
		else if (latch_cnt_r != 2'h0)
		begin
			latch_cnt_r <= latch_cnt_r - 2'h1;
		end
	end

	// lower byte staged until the upper write commits it
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			lower_stage_r <= FILTER_RESET[7:0];
		end
		else if (lower_wr)
		begin
			lower_stage_r <= wdata_i;
		end
	end

	// upper write commits all twelve bits at once
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			filter_r <= FILTER_RESET;
		end
		else if (upper_wr)
		begin
			filter_r <= {wdata_i[3:0], lower_stage_r};
		end
	end

	// trim: binary value straight to the period generator
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			trim_r <= TRIM_RESET;
		end
		else if (wr_i && addr_i == ADDR_TRIM)
		begin
			trim_r <= wdata_i;
		end
	end

	// registered outputs, one flop stage each
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			loop_filter_value_o <= FILTER_RESET;
		end
		else
		begin
			loop_filter_value_o <= filter_r;
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ref_trim_o <= TRIM_RESET;
		end
		else
		begin
			ref_trim_o <= trim_r;
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			clock_mode_status_field_o <= SEL_SELF;
		end
		else
		begin
			clock_mode_status_field_o <= mode_r;
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			osc_monitor_en_o <= 1'b0;
		end
		else
		begin
			osc_monitor_en_o <= state_r == ST_RUN && mode_r == SEL_SELF && stable;
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			osc_off_o <= 1'b1;
		end
		else
		begin
			osc_off_o <= state_r == ST_OFF;
		end
	end

	// read decode
	always_comb
	begin
		rd_value = 8'h00;
		if (addr_i == ADDR_STATUS_TWO)
		begin
			rd_value = {7'h00, stable};
		end
		else if (addr_i == ADDR_FILTER_UPPER)
		begin
			rd_value = {4'h0, filter_r[11:8]};
		end
		else if (addr_i == ADDR_FILTER_LOWER)
		begin
			rd_value = filter_r[7:0];
		end
		else if (addr_i == ADDR_TRIM)
		begin
			rd_value = trim_r;
		end
		else if (addr_i == ADDR_CONTROL)
		begin
			rd_value = {5'h00, off_r, sel_r};
		end
		else if (addr_i == ADDR_MODE_STATUS)
		begin
			rd_value = {mode_r, 6'h00};
		end
	end

	// read port, data one cycle after strobe
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rdata_o <= 8'h00;
		end
		else if (rd_i)
		begin
			rdata_o <= rd_value;
		end
		else
		begin
			rdata_o <= 8'h00;
		end
	end
endmodule

// ### verification/dft_filter_trim_asserts.sv
module dft_chk
	import dft_pkg::*;
(
	// clock and reset
	input wire logic        sys_clk_i,
	input wire logic        resetn_i,
	// register port
	input wire logic [2:0]  addr_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [7:0]  rdata_o,
	// generator side
	input wire logic [11:0] loop_filter_value_o,
	input wire logic [7:0]  ref_trim_o,
	input wire logic [1:0]  clock_mode_status_field_o,
	input wire logic        osc_monitor_en_o,
	input wire logic        osc_off_o
);
	default clocking dcb @(posedge sys_clk_i);
	endclocking
	default disable iff (!resetn_i);
	sequence fchg_s;
		$changed(loop_filter_value_o);
	endsequence
	chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data not zero outside read");
	chk_filter_cause: assert property (fchg_s
		|-> $past(wr_i && addr_i == ADDR_FILTER_UPPER, 2))
		else $error("filter changed without upper write");
	chk_latch_hold: assert property (fchg_s |=> $stable(loop_filter_value_o)[*2])
		else $error("filter changed during latch");
	chk_upper_read: assert property ($past(rd_i && addr_i == ADDR_FILTER_UPPER)
		|-> rdata_o[3:0] == loop_filter_value_o[11:8])
		else $error("upper read differs from filter");
	chk_lower_read: assert property ($past(rd_i && addr_i == ADDR_FILTER_LOWER)
		|-> rdata_o == loop_filter_value_o[7:0])
		else $error("lower read differs from filter");
	chk_trim_read: assert property ($past(rd_i && addr_i == ADDR_TRIM)
		|-> rdata_o == ref_trim_o)
		else $error("trim read differs from trim");
	chk_mode_read: assert property ($past(rd_i && addr_i == ADDR_MODE_STATUS)
		|-> rdata_o[7:6] == clock_mode_status_field_o)
		else $error("mode read differs from mode");
	chk_monitor_gate: assert property (osc_monitor_en_o
		|-> clock_mode_status_field_o == SEL_SELF && !osc_off_o)
		else $error("monitor on outside self-clocked");
	chk_off_unstable: assert property (osc_off_o && $past(osc_off_o && rd_i
		&& addr_i == ADDR_STATUS_TWO) |-> !rdata_o[STABLE_BIT])
		else $error("stable flag set while off");
endmodule
bind dft_filter_trim dft_chk u_chk (.sys_clk_i, .resetn_i, .addr_i, .wr_i, .rd_i, .rdata_o,
	.loop_filter_value_o, .ref_trim_o, .clock_mode_status_field_o, .osc_monitor_en_o, .osc_off_o);

// ### verification/tb.sv
module tb
	import dft_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, rd_d = 0;
	logic        osc_output_clock_i = 0, osc_run = 0;
	logic [2:0]  addr_i = 0;
	logic [7:0]  wdata_i = 0, osc_count_i = 0, rdata_o, ref_trim_o, t;
	logic [11:0] loop_filter_value_o, f;
	logic [1:0]  clock_mode_status_field_o;
	logic        osc_monitor_en_o, osc_off_o;
	logic [15:0] exp_q[$], n;
	int          err_total = 0, checks_done = 0;
	dft_filter_trim dut (.sys_clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.osc_output_clock_i, .osc_count_i, .loop_filter_value_o, .ref_trim_o,
		.clock_mode_status_field_o, .osc_monitor_en_o, .osc_off_o);
	initial forever #12.5 sys_clk_i = ~sys_clk_i;
	task automatic cmp(input logic [11:0] got, input logic [11:0] e);
		checks_done++;
		if (got !== e)
		begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, e);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		{addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
		@(posedge sys_clk_i);
		wr_i <= 0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge sys_clk_i);
		{addr_i, rd_i} <= {a, 1'b1};
		exp_q.push_back({m, e});
		@(posedge sys_clk_i);
		rd_i <= 0;
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// oscillator activity while running
	always @(posedge sys_clk_i)
	begin
		rd_d <= rd_i;
		if (osc_run)
			osc_output_clock_i <= ~osc_output_clock_i;
	end
	always @(negedge sys_clk_i)
		if (rd_d)
		begin
			n = exp_q.pop_front();
			cmp({4'h0, rdata_o & n[15:8]}, {4'h0, n[7:0]});
		end
	initial
	begin
		#(25 * 4000);
		err_total++;
		report_and_stop();
	end
	initial
	begin
		void'($urandom(32'h319b2f4c));
		repeat (3) @(posedge sys_clk_i);
		resetn_i <= 1;
		osc_count_i <= $urandom;
		rd(ADDR_TRIM, 8'hff, TRIM_RESET);
		rd(ADDR_CONTROL, 8'hff, CONTROL_RESET);
		rd(ADDR_FILTER_UPPER, 8'h0f, {4'h0, FILTER_RESET[11:8]});
		rd(ADDR_STATUS_TWO, 8'h01, 8'h00);
		rd(3'h7, 8'hff, 8'h00);
		t = $urandom;
		wr(ADDR_TRIM, t);
		rd(ADDR_TRIM, 8'hff, t);
		@(negedge sys_clk_i);
		cmp({4'h0, ref_trim_o}, {4'h0, t});
		f = $urandom;
		wr(ADDR_FILTER_LOWER, f[7:0]);
		wr(ADDR_FILTER_UPPER, {4'h0, f[11:8]});
		wr(ADDR_FILTER_UPPER, {4'h0, ~f[11:8]});
		repeat (3) @(negedge sys_clk_i);
		cmp(loop_filter_value_o, f);
		rd(ADDR_FILTER_LOWER, 8'hff, f[7:0]);
		wr(ADDR_CONTROL, {6'h0, SEL_INT_LOOP});
		wr(ADDR_FILTER_LOWER, ~f[7:0]);
		wr(ADDR_FILTER_UPPER, {4'h0, ~f[11:8]});
		rd(ADDR_MODE_STATUS, 8'hc0, 8'h00);
		rd(ADDR_FILTER_UPPER, 8'h0f, {4'h0, f[11:8]});
		osc_run <= 1;
		repeat (SAMPLE_CYCLES * 5) @(posedge sys_clk_i);
		rd(ADDR_STATUS_TWO, 8'h01, 8'h01);
		for (int s = 3; s >= 0; s--)
		begin
			wr(ADDR_CONTROL, s[7:0]);
			repeat (SAMPLE_CYCLES * 3) @(posedge sys_clk_i);
			rd(ADDR_MODE_STATUS, 8'hc0, {s[1:0], 6'h0});
		end
		@(negedge sys_clk_i);
		cmp({11'h0, osc_monitor_en_o}, 12'h001);
		wr(ADDR_CONTROL, CONTROL_RESET);
		// the flag drops one cycle after the off state is entered
		@(posedge sys_clk_i);
		rd(ADDR_STATUS_TWO, 8'h01, 8'h00);
		repeat (2) @(negedge sys_clk_i);
		cmp({10'h0, osc_off_o, osc_monitor_en_o}, 12'h002);
		osc_run <= 0;
		wr(ADDR_CONTROL, {6'h0, SEL_SELF});
		repeat (SAMPLE_CYCLES * 4) @(posedge sys_clk_i);
		rd(ADDR_MODE_STATUS, 8'hc0, 8'h00);
		rd(ADDR_STATUS_TWO, 8'h01, 8'h00);
		@(negedge sys_clk_i);
		cmp({10'h0, osc_off_o, osc_monitor_en_o}, 12'h000);
		report_and_stop();
	end
endmodule
